// ### hdl/mia_pkg.sv
package mia_pkg;
   // Image lengths in bytes and set identities
   localparam int FULL_LEN = 41;
   localparam int EXT_LEN = 68;
   localparam logic [7:0] FULL_INST = 8'h74;
   localparam logic [7:0] EXT_INST = 8'h72;
   localparam int IMG_BITS = EXT_LEN * 8;
   localparam int CNT_W = 7;
   // Byte offsets of the full monitoring set
   localparam int OFS_STATUS = 0;
   localparam int OFS_CUR_A = 2;
   localparam int OFS_CUR_B = 4;
   localparam int OFS_CUR_C = 6;
   localparam int OFS_FIELD = 8;
   localparam int OFS_CUR_AVG = 10;
   localparam int OFS_V12 = 12;
   localparam int OFS_V23 = 14;
   localparam int OFS_V31 = 16;
   localparam int OFS_VAVG_FULL = 18;
   localparam int OFS_POWER = 20;
   localparam int OFS_VIMB = 24;
   localparam int OFS_CIMB = 25;
   // Byte offsets of the extended set tail
   localparam int OFS_VAVG_EXT = 20;
   localparam int OFS_CARDS = 22;
   localparam int NUM_CARDS = 8;
   localparam int OFS_ANALOG = 30;
   localparam int ANALOG_WORDS = 19;
   // Register word addresses
   localparam logic [2:0] REG_CTRL = 3'h0;
   localparam logic [2:0] REG_STATUS = 3'h1;
   localparam logic [2:0] REG_SCALE = 3'h2;
   localparam logic [2:0] REG_IRQ_STAT = 3'h3;
   localparam logic [2:0] REG_IRQ_EN = 3'h4;
   localparam logic [2:0] REG_IRQ_CLR = 3'h5;
   // Field positions
   localparam int CTRL_START = 0;
   localparam int CTRL_EXT = 1;
   localparam int IRQ_DONE = 0;
   localparam int IRQ_REFUSED = 1;
   localparam int STAT_BUSY = 0;
   localparam int STAT_EXT = 1;
   localparam int STAT_INST = 8;
   localparam int STAT_CNT = 16;
   // Reset values
   localparam logic [15:0] SCALE_RST = 16'h0001;
   localparam logic [1:0] IRQ_EN_RST = 2'h0;

   typedef enum logic [0:0] {
      ST_IDLE = 1'b0,
      ST_SEND = 1'b1
   } mia_state_type;

   typedef struct packed {
      mia_state_type state;
      logic ext;
      logic sel_ext;
      logic [CNT_W-1:0] count;
      logic [IMG_BITS-1:0] img;
      logic [15:0] scale;
      logic [1:0] irq_stat;
      logic [1:0] irq_en;
      logic ack;
      logic [31:0] rdata;
   } mia_regs_type;
endpackage : mia_pkg

// ### hdl/mia_framer.sv
// The implementer's own choices: the register offsets and the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
module mia_framer (
   input wire logic ref_clk_i,
   input wire logic arst_n_i,
   // Avalon-MM slave, word addressed
   input wire logic [2:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   output logic irq_o,
   // Frame request from the network side, one-cycle pulse
   input wire logic start_i,
   // Measurement values, same clock domain
   input wire logic faulted_i,
   input wire logic warning_i,
   input wire logic [2:0] relay_outputs_i,
   input wire logic [3:0] relay_inputs_i,
   input wire logic run_state_one_i,
   input wire logic run_state_two_i,
   input wire logic network_control_active_i,
   input wire logic inhibited_i,
   input wire logic ready_i,
   input wire logic at_reference_speed_i,
   input wire logic [2:0][15:0] phase_current_i,
   input wire logic [15:0] field_input_states_i,
   input wire logic [15:0] voltage_l1_l2_i,
   input wire logic [15:0] voltage_l2_l3_i,
   input wire logic [15:0] voltage_l3_l1_i,
   input wire logic [15:0] mean_line_voltage_i,
   input wire logic [31:0] real_power_i,
   input wire logic [7:0] voltage_imbalance_pct_i,
   input wire logic [7:0] current_imbalance_pct_i,
   input wire logic [mia_pkg::NUM_CARDS-1:0][7:0] card_inputs_i,
   input wire logic [mia_pkg::ANALOG_WORDS-1:0][15:0] analog_words_i,
   // Byte stream out
   output logic tx_valid_o,
   input wire logic tx_ready_i,
   output logic [7:0] tx_data_o,
   output logic tx_first_o,
   output logic tx_last_o
);
   import mia_pkg::*;

   mia_regs_type s;
   mia_regs_type next_s;

   logic [2:0][31:0] cur_prod;
   logic [17:0] cur_sum;
   logic [15:0] cur_mean;
   logic [31:0] mean_prod;
   logic [15:0] packed_status_word;
   logic [CNT_W-1:0] last_idx;
   logic bus_req;
   logic bus_take;
   logic wr_take;
   logic byte_take;
   logic at_last;
   logic [31:0] status_word;
   wire logic [15:0] scale_wr;
   wire logic [IMG_BITS-1:0] img_full;
   wire logic [IMG_BITS-1:0] img_ext;

   genvar g;

   // A request is taken while ack is low and answered while ack is high
   assign bus_req = avs_read_i | avs_write_i;
   assign bus_take = bus_req & ~s.ack;
   assign wr_take = avs_write_i & s.ack;

   // A byte leaves on every edge where the sink is ready during a frame
   assign byte_take = (s.state == ST_SEND) & tx_ready_i;

   // Each byte lane of the scale word is written on its own
   generate
      for (g = 0; g < 2; g++) begin : g_lane
         assign scale_wr[g*8 +: 8] = avs_byteenable_i[g] ? avs_writedata_i[g*8 +: 8]
                                                          : s.scale[g*8 +: 8];
      end
   endgenerate

   // Status view; the byte index shows how far the running frame has got
   always_comb begin : status_view
      status_word = 32'h0000_0000;
      status_word[STAT_BUSY] = (s.state == ST_SEND);
      status_word[STAT_EXT] = s.ext;
      status_word[STAT_INST +: 8] = s.ext ? EXT_INST : FULL_INST;
      status_word[STAT_CNT +: CNT_W] = s.count;
   end : status_view

   // Scaling keeps the low 16 bits; software picks a factor that cannot overflow
   generate
      for (g = 0; g < 3; g++) begin : g_phase
         assign cur_prod[g] = phase_current_i[g] * s.scale;
         assign img_full[(OFS_CUR_A+2*g)*8 +: 8] = cur_prod[g][7:0];
         assign img_full[(OFS_CUR_A+2*g+1)*8 +: 8] = cur_prod[g][15:8];
      end
   endgenerate

   // Mean is taken before scaling so the three truncations do not add up
   assign cur_sum = 18'(phase_current_i[0]) + 18'(phase_current_i[1])
                  + 18'(phase_current_i[2]);
   assign cur_mean = 16'(cur_sum / 18'd3);
   assign mean_prod = cur_mean * s.scale;

   assign packed_status_word = {
      at_reference_speed_i,
      ready_i,
      inhibited_i,
      1'b0,
      relay_outputs_i[2],
      network_control_active_i,
      run_state_two_i,
      run_state_one_i,
      relay_inputs_i,
      relay_outputs_i[1],
      relay_outputs_i[0],
      warning_i,
      faulted_i
   };

   assign last_idx = s.ext ? CNT_W'(EXT_LEN - 1) : CNT_W'(FULL_LEN - 1);
   assign at_last = (s.count == last_idx);

   // Full monitoring image, every multi-byte field low byte first
   assign img_full[OFS_STATUS*8 +: 8] = packed_status_word[7:0];
   assign img_full[(OFS_STATUS+1)*8 +: 8] = packed_status_word[15:8];

   assign img_full[OFS_FIELD*8 +: 8] = field_input_states_i[7:0];
   assign img_full[(OFS_FIELD+1)*8 +: 8] = field_input_states_i[15:8];

   assign img_full[OFS_CUR_AVG*8 +: 8] = mean_prod[7:0];
   assign img_full[(OFS_CUR_AVG+1)*8 +: 8] = mean_prod[15:8];

   assign img_full[OFS_V12*8 +: 8] = voltage_l1_l2_i[7:0];
   assign img_full[(OFS_V12+1)*8 +: 8] = voltage_l1_l2_i[15:8];
   assign img_full[OFS_V23*8 +: 8] = voltage_l2_l3_i[7:0];
   assign img_full[(OFS_V23+1)*8 +: 8] = voltage_l2_l3_i[15:8];
   assign img_full[OFS_V31*8 +: 8] = voltage_l3_l1_i[7:0];
   assign img_full[(OFS_V31+1)*8 +: 8] = voltage_l3_l1_i[15:8];

   assign img_full[OFS_VAVG_FULL*8 +: 8] = mean_line_voltage_i[7:0];
   assign img_full[(OFS_VAVG_FULL+1)*8 +: 8] = mean_line_voltage_i[15:8];

   assign img_full[OFS_POWER*8 +: 8] = real_power_i[7:0];
   assign img_full[(OFS_POWER+1)*8 +: 8] = real_power_i[15:8];
   assign img_full[(OFS_POWER+2)*8 +: 8] = real_power_i[23:16];
   assign img_full[(OFS_POWER+3)*8 +: 8] = real_power_i[31:24];

   assign img_full[OFS_VIMB*8 +: 8] = voltage_imbalance_pct_i;
   assign img_full[OFS_CIMB*8 +: 8] = current_imbalance_pct_i;

   // Fields past the imbalance bytes are not produced here and go out as zero
   assign img_full[IMG_BITS-1:(OFS_CIMB+1)*8] = '0;

   // Extended image tail; the head of that set is not produced here
   assign img_ext[OFS_VAVG_EXT*8-1:0] = '0;
   assign img_ext[OFS_VAVG_EXT*8 +: 8] = mean_line_voltage_i[7:0];
   assign img_ext[(OFS_VAVG_EXT+1)*8 +: 8] = mean_line_voltage_i[15:8];

   // Card one lands in the low byte of the first word
   generate
      for (g = 0; g < NUM_CARDS; g++) begin : g_card
         assign img_ext[(OFS_CARDS+g)*8 +: 8] = card_inputs_i[g];
      end
   endgenerate

   generate
      for (g = 0; g < ANALOG_WORDS; g++) begin : g_analog
         assign img_ext[(OFS_ANALOG+2*g)*8 +: 8] = analog_words_i[g][7:0];
         assign img_ext[(OFS_ANALOG+2*g+1)*8 +: 8] = analog_words_i[g][15:8];
      end
   endgenerate

   always_comb begin : comb
      logic [IMG_BITS-1:0] img;
      logic [31:0] rd;
      logic start_req;
      logic sel;
      logic [1:0] clr;
      logic [1:0] evt;
      img = '0;
      rd = 32'h0000_0000;
      start_req = start_i;
      sel = s.sel_ext;
      clr = 2'h0;
      evt = 2'h0;
      next_s = s;

      // Answer one cycle after the request appears, so every access has one wait state
      next_s.ack = bus_take;

      unique case (avs_address_i)
         REG_CTRL: begin
            // Start is a strobe and always reads back as zero
            rd[CTRL_EXT] = s.sel_ext;
         end
         REG_STATUS: begin
            rd = status_word;
         end
         REG_SCALE: begin
            rd[15:0] = s.scale;
         end
         REG_IRQ_STAT: begin
            rd[1:0] = s.irq_stat;
         end
         REG_IRQ_EN: begin
            rd[1:0] = s.irq_en;
         end
         REG_IRQ_CLR: begin
            // Write-only
            rd = 32'h0000_0000;
         end
         default: begin
            rd = 32'h0000_0000;
         end
      endcase

      // Read data is caught when the request is taken and held through the answer
      if (bus_take) begin
         next_s.rdata = rd;
      end

      if (wr_take) begin
         unique case (avs_address_i)
            REG_CTRL: begin
               if (avs_byteenable_i[0]) begin
                  sel = avs_writedata_i[CTRL_EXT];
                  next_s.sel_ext = sel;
                  start_req = start_req | avs_writedata_i[CTRL_START];
               end
            end
            REG_SCALE: begin
               next_s.scale = scale_wr;
            end
            REG_IRQ_EN: begin
               if (avs_byteenable_i[0]) begin
                  next_s.irq_en = avs_writedata_i[1:0];
               end
            end
            REG_IRQ_CLR: begin
               if (avs_byteenable_i[0]) begin
                  clr = avs_writedata_i[1:0];
               end
            end
            default: begin
               clr = 2'h0;
            end
         endcase
      end

      // Both images are always built; the selection only picks which one is caught
      img = sel ? img_ext : img_full;

      unique case (s.state)
         ST_IDLE: begin
            if (start_req) begin
               // Whole image captured in one cycle so no field can tear
               next_s.img = img;
               next_s.ext = sel;
               next_s.count = '0;
               next_s.state = ST_SEND;
            end
         end
         ST_SEND: begin
            // A request mid-frame is dropped, not queued
            evt[IRQ_REFUSED] = start_req;
            if (byte_take) begin
               next_s.img = s.img >> 8;
               next_s.count = s.count + 1'b1;
               if (at_last) begin
                  next_s.state = ST_IDLE;
                  next_s.count = '0;
                  evt[IRQ_DONE] = 1'b1;
               end
            end
         end
      endcase

      // Set wins over a clear in the same cycle
      next_s.irq_stat = (s.irq_stat & ~clr) | evt;
   end : comb

   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         s.state <= ST_IDLE;
         s.ext <= 1'b0;
         s.sel_ext <= 1'b0;
         s.count <= '0;
         s.img <= '0;
         s.scale <= SCALE_RST;
         s.irq_stat <= 2'h0;
         s.irq_en <= IRQ_EN_RST;
         s.ack <= 1'b0;
         s.rdata <= 32'h0000_0000;
      end else begin
         s <= next_s;
      end
   end

   assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~s.ack;
   assign avs_readdata_o = s.rdata;
   assign irq_o = |(s.irq_stat & s.irq_en);
   assign tx_valid_o = (s.state == ST_SEND);
   assign tx_data_o = s.img[7:0];
   assign tx_first_o = tx_valid_o & (s.count == '0);
   assign tx_last_o = tx_valid_o & (s.count == last_idx);
endmodule : mia_framer
`default_nettype wire

// ### testbench/mia_framer_props.sv
`timescale 1ns/1ps
`default_nettype none
module mia_props (
   input wire logic ref_clk_i,
   input wire logic arst_n_i,
   input wire logic avs_read_i,
   input wire logic avs_waitrequest_o,
   input wire logic start_i,
   input wire logic tx_valid_o,
   input wire logic tx_ready_i,
   input wire logic [7:0] tx_data_o,
   input wire logic tx_first_o,
   input wire logic tx_last_o
);
   logic [6:0] cnt;
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!arst_n_i);
   // Bytes accepted so far in the running frame
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) cnt <= 7'h0;
      else if (tx_valid_o && tx_ready_i) cnt <= tx_last_o ? 7'h0 : cnt + 7'h1;
   end
   chk_wait_state: assert property ($rose(avs_read_i) |-> avs_waitrequest_o ##1 !avs_waitrequest_o)
      else $error("bus answer not after one wait state");
   chk_start_first: assert property (start_i && !tx_valid_o |=> tx_valid_o && tx_first_o)
      else $error("frame did not open after start");
   chk_byte_hold: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o)
      && $stable(tx_first_o) && $stable(tx_last_o))
      else $error("byte changed while stalled");
   chk_last_gap: assert property (tx_valid_o && tx_ready_i && tx_last_o |=> !tx_valid_o)
      else $error("no gap after last byte");
   chk_frame_len: assert property (tx_valid_o && tx_last_o |-> cnt == 7'h28 || cnt == 7'h43)
      else $error("frame length wrong");
   chk_first_zero: assert property (tx_valid_o && tx_first_o |-> cnt == 7'h0)
      else $error("first flag away from byte zero");
   chk_idle_quiet: assert property (!tx_valid_o |-> !tx_first_o && !tx_last_o)
      else $error("frame flags outside frame");
   chk_valid_hold: assert property (tx_valid_o && !(tx_ready_i && tx_last_o) |=> tx_valid_o)
      else $error("frame cut short");
endmodule : mia_props
bind mia_framer mia_props i_mia_props (.*);
`default_nettype wire

// ### testbench/mia_sink.sv
`timescale 1ns/1ps
`default_nettype none
module mia_sink (
   input wire logic ref_clk_i,
   input wire logic arst_n_i,
   input wire logic stall_i,
   input wire logic valid_i,
   output logic ready_o
);
   logic [1:0] ph;
   // Slow mode refuses one cycle in four so held bytes get seen
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) ph <= 2'h0;
      else ph <= ph + 2'h1;
   end
   assign ready_o = valid_i && (!stall_i || ph != 2'h3);
endmodule : mia_sink
`default_nettype wire

// ### testbench/tb_mia_framer.sv
`timescale 1ns/1ps
`default_nettype none
module tb_mia_framer;
   import mia_pkg::*;
   logic ref_clk_i = 0, arst_n_i = 0;
   logic [2:0] avs_address_i, relay_outputs_i;
   logic avs_read_i, avs_write_i, start_i, stall, avs_waitrequest_o, irq_o;
   logic [31:0] avs_writedata_i, avs_readdata_o, real_power_i, rv;
   logic [3:0] avs_byteenable_i, relay_inputs_i;
   logic tx_valid_o, tx_ready_i, tx_first_o, tx_last_o, faulted_i, warning_i;
   logic run_state_one_i, run_state_two_i, network_control_active_i;
   logic inhibited_i, ready_i, at_reference_speed_i;
   logic [2:0][15:0] phase_current_i;
   logic [15:0] field_input_states_i, voltage_l1_l2_i, voltage_l2_l3_i, voltage_l3_l1_i;
   logic [15:0] mean_line_voltage_i;
   logic [7:0] voltage_imbalance_pct_i, current_imbalance_pct_i, tx_data_o;
   logic [NUM_CARDS-1:0][7:0] card_inputs_i;
   logic [ANALOG_WORDS-1:0][15:0] analog_words_i;
   logic [7:0] got [EXT_LEN], exp [EXT_LEN];
   int err_count = 0, samples_checked = 0, n = 0, frames = 0, cyc = 0;
   localparam logic [15:0] ST = 16'hc3a5;
   mia_framer i_mia_framer (.*);
   mia_sink i_mia_sink (.ref_clk_i, .arst_n_i, .stall_i(stall), .valid_i(tx_valid_o),
      .ready_o(tx_ready_i));
   always #10 ref_clk_i = ~ref_clk_i;
   // Sampled mid-cycle, where the byte and the handshake are settled
   always @(negedge ref_clk_i) begin
      if (tx_valid_o && tx_ready_i) begin
         if (tx_first_o) n = 0;
         if (n < EXT_LEN) got[n] = tx_data_o;
         n++;
         if (tx_last_o) frames++;
      end
      cyc++;
      if (cyc == 20000) begin
         err_count++;
         results();
      end
   end
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] want);
      samples_checked++;
      if (seen !== want) begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", nm, want, seen);
      end
   endtask : chk
   task automatic bus(input logic wr, input logic [2:0] a, input logic [31:0] d);
      @(posedge ref_clk_i);
      avs_address_i <= a;
      avs_writedata_i <= d;
      avs_write_i <= wr;
      avs_read_i <= !wr;
      do @(posedge ref_clk_i); while (avs_waitrequest_o !== 1'b0);
      rv = avs_readdata_o;
      avs_write_i <= 1'b0;
      avs_read_i <= 1'b0;
   endtask : bus
   task automatic put16(input int o, input logic [15:0] v);
      exp[o] = v[7:0];
      exp[o + 1] = v[15:8];
   endtask : put16
   task automatic fill(input logic ext, input logic [15:0] sc);
      int m;
      foreach (exp[i]) exp[i] = 8'h0;
      if (!ext) begin
         put16(0, ST);
         for (int k = 0; k < 3; k++) put16(2 + 2 * k, phase_current_i[k] * sc);
         put16(8, field_input_states_i);
         m = (phase_current_i[0] + phase_current_i[1] + phase_current_i[2]) / 3;
         put16(10, m * sc);
         put16(12, voltage_l1_l2_i);
         put16(14, voltage_l2_l3_i);
         put16(16, voltage_l3_l1_i);
         put16(18, mean_line_voltage_i);
         put16(20, real_power_i[15:0]);
         put16(22, real_power_i[31:16]);
         exp[24] = voltage_imbalance_pct_i;
         exp[25] = current_imbalance_pct_i;
      end else begin
         put16(20, mean_line_voltage_i);
         for (int k = 0; k < 8; k++) exp[22 + k] = card_inputs_i[k];
         for (int k = 0; k < 19; k++) put16(30 + 2 * k, analog_words_i[k]);
      end
   endtask : fill
   // Pin start also changes inputs and retries mid-frame: snapshot and refusal
   task automatic frame(input logic ext, input logic pin, input int len);
      int f;
      f = frames;
      fill(ext, 16'h0003);
      if (pin) begin
         @(posedge ref_clk_i);
         start_i <= 1'b1;
         @(posedge ref_clk_i);
         start_i <= 1'b0;
         phase_current_i <= '0;
         field_input_states_i <= 16'h0;
         repeat (2) @(posedge ref_clk_i);
         start_i <= 1'b1;
         @(posedge ref_clk_i);
         start_i <= 1'b0;
      end else bus(1'b1, REG_CTRL, {30'h0, ext, 1'b1});
      wait (frames != f);
      chk("frame length", n, len);
      for (int i = 0; i < len; i++) chk($sformatf("byte %0d", i), got[i], exp[i]);
   endtask : frame
   task automatic results();
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : results
   initial begin
      {avs_address_i, avs_read_i, avs_write_i, avs_writedata_i, start_i} = '0;
      avs_byteenable_i = 4'hf;
      stall = 1'b1;
      {at_reference_speed_i, ready_i, inhibited_i, relay_outputs_i[2], network_control_active_i,
         run_state_two_i, run_state_one_i, relay_inputs_i, relay_outputs_i[1:0], warning_i,
         faulted_i} = {ST[15:13], ST[11:0]};
      phase_current_i = {16'h0789, 16'h0456, 16'h0123};
      field_input_states_i = 16'hbeef;
      {voltage_l1_l2_i, voltage_l2_l3_i, voltage_l3_l1_i} = 48'h0190_0191_0192;
      mean_line_voltage_i = 16'h0193;
      real_power_i = 32'h1234_5678;
      {voltage_imbalance_pct_i, current_imbalance_pct_i} = 16'h070b;
      for (int i = 0; i < NUM_CARDS; i++) card_inputs_i[i] = 8'h10 + 8'(i);
      for (int i = 0; i < ANALOG_WORDS; i++) analog_words_i[i] = 16'ha000 + 16'(i);
      repeat (10) @(posedge ref_clk_i);
      arst_n_i <= 1'b1;
      bus(1'b0, REG_SCALE, 32'h0);
      chk("scale reset", rv, 32'h1);
      bus(1'b0, REG_IRQ_EN, 32'h0);
      chk("irq enable reset", rv, 32'h0);
      bus(1'b0, 3'h6, 32'h0);
      chk("unmapped read", rv, 32'h0);
      bus(1'b1, REG_SCALE, 32'h3);
      frame(1'b0, 1'b1, FULL_LEN);
      bus(1'b0, REG_STATUS, 32'h0);
      chk("full status", rv, 32'h0000_7400);
      bus(1'b0, REG_IRQ_STAT, 32'h0);
      chk("event status", rv, 32'h3);
      chk("irq masked", irq_o, 1'b0);
      bus(1'b1, REG_IRQ_EN, 32'h1);
      @(posedge ref_clk_i);
      chk("irq raised", irq_o, 1'b1);
      bus(1'b1, REG_IRQ_CLR, 32'h1);
      @(posedge ref_clk_i);
      chk("irq cleared", irq_o, 1'b0);
      bus(1'b0, REG_IRQ_STAT, 32'h0);
      chk("status after clear", rv, 32'h2);
      stall <= 1'b0;
      frame(1'b1, 1'b0, EXT_LEN);
      bus(1'b0, REG_STATUS, 32'h0);
      chk("extended status", rv, 32'h0000_7202);
      bus(1'b0, REG_CTRL, 32'h0);
      chk("set select", rv, 32'h0000_0002);
      results();
   end
endmodule : tb_mia_framer
`default_nettype wire
